/* bpg_defines.vh */
// constants shared by the bit error rate tester: register map, fields, reset values, sync counts
`ifndef BPG_DEFINES_VH
`define BPG_DEFINES_VH

// register byte offsets
`define BPG_ADDR_CTRL       8'h00
`define BPG_ADDR_CFG        8'h04
`define BPG_ADDR_SEED       8'h08
`define BPG_ADDR_STATUS     8'h0C
`define BPG_ADDR_BIT_COUNT  8'h10
`define BPG_ADDR_ERR_COUNT  8'h14

// control register fields
`define BPG_CTRL_ENABLE     0
`define BPG_CTRL_TX_LOAD    1
`define BPG_CTRL_RX_LOAD    2
`define BPG_CTRL_UPDATE     3
`define BPG_CTRL_ERR_ONE    4
`define BPG_CTRL_NO_RESYNC  5
`define BPG_CTRL_INVERT     6
`define BPG_CTRL_ERR_PIN    7
`define BPG_CTRL_MASK       32'h0000_00EF

// pattern configuration fields
`define BPG_CFG_LEN_LSB     0
`define BPG_CFG_TAP_LSB     8
`define BPG_CFG_REPEAT      16
`define BPG_CFG_QRSS        17
`define BPG_CFG_RATE_LSB    24

// status register fields
`define BPG_STAT_OOS        0
`define BPG_STAT_ERRS       1

// reset values
`define BPG_CTRL_RESET      32'h0000_0000
`define BPG_CFG_RESET       32'h0000_0000
`define BPG_SEED_RESET      32'hFFFF_FFFF

// synchronisation counts
`define BPG_SYNC_BITS       6'h20
`define BPG_WINDOW_BITS     7'h40
`define BPG_RESYNC_ERRS     7'h06

`endif

/* bpg_gen.v */
// 32-bit pattern generator shared by the transmit and receive directions
`timescale 1ns/100ps
`default_nettype none

module bpg_gen
#(
  parameter WIDTH = 32
)
(
  input  wire             clk_sys,
  input  wire             rst,
  input  wire             load,
  input  wire [WIDTH-1:0] load_val,
  input  wire             shift,
  input  wire             use_ext,
  input  wire             ext_bit,
  input  wire [4:0]       len,
  input  wire [4:0]       tap,
  input  wire             repetitive,
  input  wire             qrss,
  output reg              gen_out,
  output wire [WIDTH-1:0] sr_out
);

  reg [WIDTH-1:0] sr_reg;
  reg             fb;

  assign sr_out = sr_reg;

  // feedback and output selection; bit k of the text is sr_reg[k-1]
  always @*
  begin
    if (qrss)
      fb = sr_reg[16] ^ sr_reg[19];
    else if (repetitive)
      fb = sr_reg[len];
    else
      fb = sr_reg[len] ^ sr_reg[tap];
    if (!repetitive && (sr_reg[30:0] == 31'h0000_0000))
      fb = 1'b1;
    gen_out = fb;
    if (qrss && (sr_reg[13:0] == 14'h0000))
      gen_out = 1'b1;
  end

  // shift from bit 1 toward bit 32; received bits replace feedback while hunting
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      sr_reg <= {WIDTH{1'b0}};
    else if (load)
      sr_reg <= load_val;
    else if (shift)
      sr_reg <= {sr_reg[WIDTH-2:0], use_ext ? ext_bit : fb};
  end

endmodule

`default_nettype wire

/* bpg_top.v */
// bit error rate tester: pattern generator, error insertion, receive sync and counters, register slave
`timescale 1ns/100ps
`default_nettype none
`include "bpg_defines.vh"

module bpg_top
#(
  parameter BIT_CNT_W = 32,
  parameter ERR_CNT_W = 24
)
(
  input  wire        clk_sys,
  input  wire        rst,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        tx_bit_req,
  output reg         tx_bit_out,
  output reg         tx_bit_valid,
  input  wire        rx_bit_in,
  input  wire        rx_bit_valid,
  input  wire        manual_error_insert_input,
  output reg         out_of_sync_flag,
  output reg         errors_seen_flag
);

  localparam ST_HUNT   = 2'b00;
  localparam ST_VERIFY = 2'b01;
  localparam ST_SYNC   = 2'b10;

  reg  [31:0]          ctrl_reg;
  reg  [31:0]          cfg_reg;
  reg  [31:0]          seed_reg;
  reg  [31:0]          rx_pat_reg;
  reg  [2:0]           edge_prev_reg;
  reg                  pin_prev_reg;
  reg  [3:0]           pend_reg;
  reg  [23:0]          rate_cnt_reg;
  reg  [23:0]          rate_limit;
  reg  [1:0]           state_reg;
  reg  [1:0]           state_next;
  reg  [5:0]           cnt_reg;
  reg  [5:0]           cnt_next;
  reg  [5:0]           win_reg;
  reg  [5:0]           win_next;
  reg  [2:0]           werr_reg;
  reg  [2:0]           werr_next;
  reg  [BIT_CNT_W-1:0] bit_cnt_reg;
  reg  [ERR_CNT_W-1:0] err_cnt_reg;
  reg  [BIT_CNT_W-1:0] bit_lat_reg;
  reg  [ERR_CNT_W-1:0] err_lat_reg;
  reg  [31:0]          rd_mux;

  wire                 bus_take;
  wire                 wr_take;
  wire                 enable;
  wire                 tx_load_edge;
  wire                 rx_load_edge;
  wire                 upd_edge;
  wire                 err_req;
  wire                 tx_step;
  wire                 rate_hit;
  wire                 insert;
  wire                 tx_gen_out;
  wire                 rx_gen_out;
  wire [31:0]          rx_sr;
  wire [31:0]          len_mask;
  wire [31:0]          hunt_view;
  wire                 rep_match;
  wire                 rx_step;
  wire                 mism;
  wire                 counting;
  wire [4:0]           len;
  wire [4:0]           tap;
  wire                 repetitive;
  wire                 qrss;
  wire [2:0]           rate_n;

  assign enable     = ctrl_reg[`BPG_CTRL_ENABLE];
  assign len        = cfg_reg[`BPG_CFG_LEN_LSB+4:`BPG_CFG_LEN_LSB];
  assign tap        = cfg_reg[`BPG_CFG_TAP_LSB+4:`BPG_CFG_TAP_LSB];
  assign repetitive = cfg_reg[`BPG_CFG_REPEAT] & ~cfg_reg[`BPG_CFG_QRSS];
  assign qrss       = cfg_reg[`BPG_CFG_QRSS];
  assign rate_n     = cfg_reg[`BPG_CFG_RATE_LSB+2:`BPG_CFG_RATE_LSB];

  // bus handshake: one wait cycle per request, then accept on the edge seen with waitrequest low
  assign bus_take = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_take  = bus_take & avs_write;

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
  end

  // read mux; unmapped addresses read zero
  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `BPG_ADDR_CTRL:      rd_mux = ctrl_reg;
      `BPG_ADDR_CFG:       rd_mux = cfg_reg;
      `BPG_ADDR_SEED:      rd_mux = seed_reg;
      `BPG_ADDR_STATUS:    rd_mux = {30'h0000_0000, errors_seen_flag, out_of_sync_flag};
      `BPG_ADDR_BIT_COUNT: rd_mux = bit_lat_reg;
      `BPG_ADDR_ERR_COUNT: rd_mux = {8'h00, err_lat_reg};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // read data settles during the wait cycle so it stands at the accepting edge
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && avs_waitrequest)
      avs_readdata <= rd_mux;
  end

  // register writes; the single-error bit is a strobe and is never stored
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= `BPG_CTRL_RESET;
      cfg_reg  <= `BPG_CFG_RESET;
      seed_reg <= `BPG_SEED_RESET;
    end
    else if (wr_take)
    begin
      case (avs_address)
        `BPG_ADDR_CTRL: ctrl_reg <= avs_writedata & `BPG_CTRL_MASK;
        `BPG_ADDR_CFG:  cfg_reg  <= avs_writedata & 32'h071F_1F1F;
        `BPG_ADDR_SEED: seed_reg <= avs_writedata;
        default:        ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // zero-to-one detection on load and update bits; a load needs the enable bit set by the same write or earlier
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      edge_prev_reg <= 3'h0;
      pin_prev_reg  <= 1'b0;
    end
    else
    begin
      edge_prev_reg <= ctrl_reg[`BPG_CTRL_UPDATE:`BPG_CTRL_TX_LOAD];
      pin_prev_reg  <= manual_error_insert_input;
    end
  end

  assign tx_load_edge = enable & ctrl_reg[`BPG_CTRL_TX_LOAD] & ~edge_prev_reg[0];
  assign rx_load_edge = enable & ctrl_reg[`BPG_CTRL_RX_LOAD] & ~edge_prev_reg[1];
  assign upd_edge     = ctrl_reg[`BPG_CTRL_UPDATE] & ~edge_prev_reg[2];

  // single error source picked by the method bit
  assign err_req = ctrl_reg[`BPG_CTRL_ERR_PIN] ?
                   (manual_error_insert_input & ~pin_prev_reg) :
                   (wr_take & (avs_address == `BPG_ADDR_CTRL) & avs_writedata[`BPG_CTRL_ERR_ONE]);

  // ten to the n bits between rate errors; zero turns rate insertion off
  always @*
  begin
    case (rate_n)
      3'h1:    rate_limit = 24'h00_000A;
      3'h2:    rate_limit = 24'h00_0064;
      3'h3:    rate_limit = 24'h00_03E8;
      3'h4:    rate_limit = 24'h00_2710;
      3'h5:    rate_limit = 24'h01_86A0;
      3'h6:    rate_limit = 24'h0F_4240;
      3'h7:    rate_limit = 24'h98_9680;
      default: rate_limit = 24'h00_0000;
    endcase
  end

  assign tx_step  = enable & tx_bit_req & ~tx_load_edge;
  assign rate_hit = (rate_n != 3'h0) && (rate_cnt_reg == rate_limit - 24'h00_0001);
  // one flip per outgoing bit at most; a single request coinciding with a rate error waits a bit
  assign insert   = rate_hit | (pend_reg != 4'h0);

  // rate counter runs on outgoing bits only
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rate_cnt_reg <= 24'h00_0000;
    else if (rate_n == 3'h0 || tx_load_edge)
      rate_cnt_reg <= 24'h00_0000;
    else if (tx_step)
      rate_cnt_reg <= rate_hit ? 24'h00_0000 : rate_cnt_reg + 24'h00_0001;
  end

  // pending single errors; a new request in the consuming cycle is kept, saturating at 15
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      pend_reg <= 4'h0;
    else if (!enable)
      pend_reg <= 4'h0;
    else if (err_req && !(tx_step && !rate_hit && pend_reg != 4'h0))
      pend_reg <= (pend_reg == 4'hF) ? pend_reg : pend_reg + 4'h1;
    else if (!err_req && tx_step && !rate_hit && pend_reg != 4'h0)
      pend_reg <= pend_reg - 4'h1;
  end

  bpg_gen u_tx_gen
  (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .load       (tx_load_edge),
    .load_val   (seed_reg),
    .shift      (tx_step),
    .use_ext    (1'b0),
    .ext_bit    (1'b0),
    .len        (len),
    .tap        (tap),
    .repetitive (repetitive),
    .qrss       (qrss),
    .gen_out    (tx_gen_out),
    .sr_out     ()
  );

  // transmit bit: pattern, then error flip, then inversion ahead of the framer's overhead merge
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tx_bit_out   <= 1'b0;
      tx_bit_valid <= 1'b0;
    end
    else
    begin
      tx_bit_valid <= tx_step;
      if (tx_step)
        tx_bit_out <= tx_gen_out ^ insert ^ ctrl_reg[`BPG_CTRL_INVERT];
    end
  end

  // receive side sees only payload strobes; the stream itself is not touched here
  assign rx_step   = enable & rx_bit_valid & ~rx_load_edge;
  assign mism      = rx_bit_in ^ rx_gen_out;
  assign len_mask  = 32'hFFFF_FFFF >> (5'd31 - len);
  assign hunt_view = {rx_sr[30:0], rx_bit_in};
  assign rep_match = ((hunt_view ^ rx_pat_reg) & len_mask) == 32'h0000_0000;

  // receive pattern held for the repetitive hunt
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rx_pat_reg <= 32'h0000_0000;
    else if (rx_load_edge)
      rx_pat_reg <= seed_reg;
  end

  bpg_gen u_rx_gen
  (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .load       (rx_load_edge),
    .load_val   (seed_reg),
    .shift      (rx_step),
    .use_ext    (state_reg == ST_HUNT),
    .ext_bit    (rx_bit_in),
    .len        (len),
    .tap        (tap),
    .repetitive (repetitive),
    .qrss       (qrss),
    .gen_out    (rx_gen_out),
    .sr_out     (rx_sr)
  );

  // sync machine: hunt, verify 32 bits, then watch 64-bit windows for resync
  always @*
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    win_next   = win_reg;
    werr_next  = werr_reg;
    if (!enable || rx_load_edge)
    begin
      state_next = ST_HUNT;
      cnt_next   = 6'h00;
    end
    else if (rx_step)
    begin
      case (state_reg)
        ST_HUNT:
        begin
          if (repetitive)
          begin
            if (rep_match)
              state_next = ST_VERIFY;
            cnt_next = 6'h00;
          end
          else if (cnt_reg == `BPG_SYNC_BITS - 6'h01)
          begin
            state_next = ST_VERIFY;
            cnt_next   = 6'h00;
          end
          else
            cnt_next = cnt_reg + 6'h01;
        end
        ST_VERIFY:
        begin
          if (mism)
          begin
            state_next = ST_HUNT;
            cnt_next   = 6'h00;
          end
          else if (cnt_reg == `BPG_SYNC_BITS - 6'h01)
          begin
            state_next = ST_SYNC;
            cnt_next   = 6'h00;
            win_next   = 6'h00;
            werr_next  = 3'h0;
          end
          else
            cnt_next = cnt_reg + 6'h01;
        end
        ST_SYNC:
        begin
          win_next  = win_reg + 6'h01;
          werr_next = (win_reg == 6'h3F) ? 3'h0 : werr_reg + {2'b00, mism};
          if (!ctrl_reg[`BPG_CTRL_NO_RESYNC] &&
              ({4'h0, werr_reg} + {6'h00, mism} >= `BPG_RESYNC_ERRS))
          begin
            state_next = ST_HUNT;
            cnt_next   = 6'h00;
          end
        end
        default:
        begin
          state_next = ST_HUNT;
          cnt_next   = 6'h00;
        end
      endcase
    end
  end

  // sync state and the out-of-sync output, which follows the next state so it never lags
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_reg        <= ST_HUNT;
      cnt_reg          <= 6'h00;
      win_reg          <= 6'h00;
      werr_reg         <= 3'h0;
      out_of_sync_flag <= 1'b1;
    end
    else
    begin
      state_reg        <= state_next;
      cnt_reg          <= cnt_next;
      win_reg          <= win_next;
      werr_reg         <= (werr_next > 3'h6) ? 3'h6 : werr_next;
      out_of_sync_flag <= (state_next != ST_SYNC);
    end
  end

  assign counting = rx_step & (state_reg == ST_SYNC);

  // running counters saturate; an update latches them and restarts from the current bit
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      bit_cnt_reg      <= {BIT_CNT_W{1'b0}};
      err_cnt_reg      <= {ERR_CNT_W{1'b0}};
      bit_lat_reg      <= {BIT_CNT_W{1'b0}};
      err_lat_reg      <= {ERR_CNT_W{1'b0}};
      errors_seen_flag <= 1'b0;
    end
    else if (upd_edge)
    begin
      bit_lat_reg      <= bit_cnt_reg;
      err_lat_reg      <= err_cnt_reg;
      errors_seen_flag <= (err_cnt_reg != {ERR_CNT_W{1'b0}});
      bit_cnt_reg      <= {{(BIT_CNT_W-1){1'b0}}, counting};
      err_cnt_reg      <= {{(ERR_CNT_W-1){1'b0}}, counting & mism};
    end
    else if (counting)
    begin
      if (bit_cnt_reg != {BIT_CNT_W{1'b1}})
        bit_cnt_reg <= bit_cnt_reg + {{(BIT_CNT_W-1){1'b0}}, 1'b1};
      if (mism && err_cnt_reg != {ERR_CNT_W{1'b1}})
        err_cnt_reg <= err_cnt_reg + {{(ERR_CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

`default_nettype wire

/* bpg_monitor.sv */
// checker for the tester's bus, transmit and sync ports
`timescale 1ns/100ps
`default_nettype none
module bpg_monitor
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic tx_bit_req,
  input wire logic tx_bit_out,
  input wire logic tx_bit_valid,
  input wire logic rx_bit_valid,
  input wire logic out_of_sync_flag,
  input wire logic errors_seen_flag
);
  logic [6:0] hunt_cnt_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // bits taken while out of sync; saturates so a long hunt cannot wrap
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      hunt_cnt_reg <= 7'h00;
    else if (!out_of_sync_flag)
      hunt_cnt_reg <= 7'h00;
    else if (rx_bit_valid && hunt_cnt_reg != 7'h7F)
      hunt_cnt_reg <= hunt_cnt_reg + 7'h01;
  end
  // bus handshake, transmit timing and sync relations
  chk_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  chk_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("waitrequest low without request");
  chk_tx_cause: assert property (tx_bit_valid |-> $past(tx_bit_req))
    else $error("transmit bit without request");
  chk_tx_hold: assert property (!tx_bit_valid |-> $stable(tx_bit_out))
    else $error("transmit bit moved between bits");
  chk_oos_fall: assert property ($fell(out_of_sync_flag) |-> $past(rx_bit_valid))
    else $error("lock without a received bit");
  chk_sync_verify: assert property ($fell(out_of_sync_flag) |-> hunt_cnt_reg >= 7'h20)
    else $error("lock before 32 verify bits");
  chk_oos_rise: assert property ($rose(out_of_sync_flag) |->
    $past(rx_bit_valid) || $past(avs_write) || $past(avs_write, 2))
    else $error("sync lost without cause");
  chk_errs_update: assert property ($changed(errors_seen_flag) |->
    $past(avs_write) || $past(avs_write, 2))
    else $error("error flag moved without update");
endmodule
`default_nettype wire

/* bpg_partner.sv */
// loopback model of the framer payload path facing the tester
`timescale 1ns/100ps
`default_nettype none
module bpg_partner
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic [15:0] quota,
  input  wire logic        tx_bit_out,
  input  wire logic        tx_bit_valid,
  output var  logic        tx_bit_req,
  output var  logic        rx_bit_in,
  output var  logic        rx_bit_valid,
  output wire logic        busy
);
  integer      seed;
  logic [15:0] left_reg;
  logic [15:0] left_next;
  initial seed = 32'h4050_8935;
  assign busy = (left_reg != 16'h0000);
  // a fresh quota replaces the count; each taken request uses one
  always @*
  begin
    left_next = go ? quota : left_reg - {15'h0000, tx_bit_req && busy};
  end
  // random gaps stand for overhead cycles; idle data line shows the inverse of its last bit
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      left_reg <= 16'h0000;
      tx_bit_req <= 1'b0;
      rx_bit_in <= 1'b0;
      rx_bit_valid <= 1'b0;
    end
    else
    begin
      left_reg <= left_next;
      tx_bit_req <= (left_next != 16'h0000) && (($random(seed) & 1) != 0);
      rx_bit_valid <= tx_bit_valid;
      rx_bit_in <= tx_bit_valid ? tx_bit_out : !rx_bit_in;
    end
  end
endmodule
`default_nettype wire

/* bpg_top_bench.sv */
// self-checking bench: registers, patterns, sync, counters, error insertion
`timescale 1ns/100ps
`default_nettype none
`include "bpg_defines.vh"
module bpg_top_bench;
  localparam logic [31:0] c_en = 32'h0000_0001, c_ld = 32'h0000_0006, c_upd = 32'h0000_0008;
  localparam logic [31:0] c_one = 32'h0000_0010, c_nors = 32'h0000_0020, c_pin = 32'h0000_0080;
  logic        clk_sys, rst, avs_read, avs_write, manual_error_insert_input, go;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, sr_m, q;
  logic [15:0] quota;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, tx_bit_req, tx_bit_out, tx_bit_valid, rx_bit_in, rx_bit_valid;
  wire         out_of_sync_flag, errors_seen_flag, busy;
  integer      failures, total_checks, seed, tx_diff, tx_cnt, rx_locked, i;
  logic        oos_seen, inv_m;
  logic [1:0]  mode_m;
  logic [4:0]  n_m, y_m;
  logic [32:0] step;
  logic [31:0] cfg_t [0:3];

  bpg_top i_dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tx_bit_req(tx_bit_req), .tx_bit_out(tx_bit_out),
    .tx_bit_valid(tx_bit_valid), .rx_bit_in(rx_bit_in), .rx_bit_valid(rx_bit_valid),
    .manual_error_insert_input(manual_error_insert_input), .out_of_sync_flag(out_of_sync_flag),
    .errors_seen_flag(errors_seen_flag));
  bpg_partner i_far (.clk_sys(clk_sys), .rst(rst), .go(go), .quota(quota), .tx_bit_out(tx_bit_out),
    .tx_bit_valid(tx_bit_valid), .tx_bit_req(tx_bit_req), .rx_bit_in(rx_bit_in),
    .rx_bit_valid(rx_bit_valid), .busy(busy));

  // reference generator: one step gives {output, next register}
  function automatic logic [32:0] gen_step(input logic [31:0] s);
    logic fb;
    begin
      fb = (mode_m == 2'h2) ? s[16] ^ s[19] : (mode_m == 2'h1) ? s[n_m] : s[n_m] ^ s[y_m];
      if (mode_m != 2'h1 && s[30:0] == 31'h0000_0000) fb = 1'b1;
      gen_step = {fb | (mode_m == 2'h2 && s[13:0] == 14'h0000), s[30:0], fb};
    end
  endfunction

  // every transmitted bit is compared with the model; locked received bits are counted
  always @(posedge clk_sys)
  begin
    if (tx_bit_valid === 1'b1)
    begin
      step = gen_step(sr_m);
      sr_m = step[31:0];
      tx_cnt = tx_cnt + 1;
      if (tx_bit_out !== (step[32] ^ inv_m)) tx_diff = tx_diff + 1;
    end
    if (rx_bit_valid === 1'b1 && out_of_sync_flag === 1'b0) rx_locked = rx_locked + 1;
    if (out_of_sync_flag === 1'b1) oos_seen = 1'b1;
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
        failures = failures + 1;
        $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
    end
  endtask

  // one bus transfer, held until waitrequest is sampled low
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    integer k;
    begin
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      k = 0;
      do
      begin
        @(posedge clk_sys);
        k = k + 1;
      end
      while (avs_waitrequest !== 1'b0 && k < 100);
      q = avs_readdata;
      if (k >= 100) failures = failures + 1;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    begin
      bus(1'b0, a, 32'h0000_0000);
      check(q, e);
    end
  endtask

  // far side sends exactly n payload requests, then the loop drains
  task run(input logic [15:0] n);
    integer k;
    begin
      @(posedge clk_sys);
      quota <= n;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      k = 0;
      do
      begin
        @(posedge clk_sys);
        k = k + 1;
      end
      while (busy !== 1'b0 && k < 20000);
      repeat (4) @(posedge clk_sys);
    end
  endtask

  task end_of_test;
    begin
      $display("failures %0d total_checks %0d", failures, total_checks);
      if (failures == 0 && total_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // watchdog well beyond the expected run length
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    failures = failures + 1;
    end_of_test;
  end

  initial
  begin
    {failures, total_checks, tx_diff, tx_cnt, rx_locked, i} = {6{32'h0000_0000}};
    seed = 32'h4050_8935;
    {rst, avs_read, avs_write, manual_error_insert_input, go, oos_seen, inv_m} = 7'h41;
    {avs_address, avs_writedata, sr_m, quota, mode_m, n_m, y_m} = 100'h0;
    cfg_t[0] = 32'h0000_0408;
    cfg_t[1] = 32'h0002_0000;
    cfg_t[2] = 32'h0001_0007;
    cfg_t[3] = 32'h0000_0D0E;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`BPG_ADDR_CTRL, `BPG_CTRL_RESET);
    rd(`BPG_ADDR_CFG, `BPG_CFG_RESET);
    rd(`BPG_ADDR_SEED, `BPG_SEED_RESET);
    rd(`BPG_ADDR_STATUS, 32'h0000_0001);
    rd(8'h18, 32'h0000_0000);
    // inverted prbs, qrss, repetitive and plain prbs, each from a fresh load
    for (i = 0; i < 4; i = i + 1)
    begin
      mode_m = (i == 1) ? 2'h2 : (i == 2) ? 2'h1 : 2'h0;
      n_m = cfg_t[i][4:0];
      y_m = cfg_t[i][12:8];
      inv_m = (i == 0);
      sr_m = $random(seed) & (32'hFFFF_FFFF >> (31 - n_m));
      bus(1'b1, `BPG_ADDR_CTRL, c_en | {25'h0, inv_m, 6'h00});
      bus(1'b1, `BPG_ADDR_CFG, cfg_t[i]);
      bus(1'b1, `BPG_ADDR_SEED, sr_m);
      bus(1'b1, `BPG_ADDR_CTRL, c_en | c_ld | {25'h0, inv_m, 6'h00});
      tx_diff = 0;
      run(16'h0258);
      check(tx_diff, 32'h0000_0000);
      check({31'h0, out_of_sync_flag}, {31'h0, inv_m});
    end
    // register, pin and rate errors with resync off
    bus(1'b1, `BPG_ADDR_CTRL, c_en | c_nors);
    bus(1'b1, `BPG_ADDR_CTRL, c_en | c_nors | c_upd);
    tx_diff = 0;
    rx_locked = 0;
    repeat (3) bus(1'b1, `BPG_ADDR_CTRL, c_en | c_nors | c_one);
    run(16'h0064);
    bus(1'b1, `BPG_ADDR_CTRL, c_en | c_nors | c_pin);
    repeat (2)
    begin
      manual_error_insert_input <= 1'b1;
      repeat (3) @(posedge clk_sys);
      manual_error_insert_input <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    run(16'h0064);
    bus(1'b1, `BPG_ADDR_CFG, 32'h0100_0D0E);
    run(16'h0064);
    bus(1'b1, `BPG_ADDR_CFG, 32'h0000_0D0E);
    check(tx_diff, 32'h0000_000F);
    bus(1'b1, `BPG_ADDR_CTRL, c_en | c_nors);
    bus(1'b1, `BPG_ADDR_CTRL, c_en | c_nors | c_upd);
    rd(`BPG_ADDR_ERR_COUNT, 32'h0000_000F);
    rd(`BPG_ADDR_BIT_COUNT, rx_locked);
    rd(`BPG_ADDR_STATUS, 32'h0000_0002);
    check({31'h0, errors_seen_flag}, 32'h0000_0001);
    // error burst with resync on: sync drops, then recovers
    bus(1'b1, `BPG_ADDR_CTRL, c_en);
    rx_locked = 0;
    oos_seen = 1'b0;
    repeat (12) bus(1'b1, `BPG_ADDR_CTRL, c_en | c_one);
    run(16'h0190);
    check({31'h0, oos_seen}, 32'h0000_0001);
    check({31'h0, out_of_sync_flag}, 32'h0000_0000);
    bus(1'b1, `BPG_ADDR_CTRL, c_en | c_upd);
    rd(`BPG_ADDR_BIT_COUNT, rx_locked);
    bus(1'b1, `BPG_ADDR_CTRL, c_en);
    bus(1'b1, `BPG_ADDR_CTRL, c_en | c_upd);
    rd(`BPG_ADDR_ERR_COUNT, 32'h0000_0000);
    check({31'h0, errors_seen_flag}, 32'h0000_0000);
    // disabled tester sends nothing
    bus(1'b1, `BPG_ADDR_CTRL, 32'h0000_0000);
    i = tx_cnt;
    run(16'h0014);
    check(tx_cnt - i, 32'h0000_0000);
    end_of_test;
  end
endmodule

bind bpg_top bpg_monitor i_mon (.clk_sys(clk_sys), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .tx_bit_req(tx_bit_req), .tx_bit_out(tx_bit_out),
  .tx_bit_valid(tx_bit_valid), .rx_bit_valid(rx_bit_valid), .out_of_sync_flag(out_of_sync_flag),
  .errors_seen_flag(errors_seen_flag));
`default_nettype wire
